// file: common/gpib_ctl_defs.vh
`ifndef GPIB_CTL_DEFS_VH
`define GPIB_CTL_DEFS_VH
// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_PERIOD_NS      25
`define SYNC_DIV           15
`define EVT_SAMPLE_CYCLES  3
`define EVT_SAMPLE_CLKS    (`EVT_SAMPLE_CYCLES * `SYNC_DIV)
`define PPOLL_TIME_NS      2000
`define PPOLL_CLKS         ((`PPOLL_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ATN_WAIT_NS        500
`define ATN_WAIT_CLKS      ((`ATN_WAIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define IFC_TIME_NS        100000
`define IFC_CLKS           (`IFC_TIME_NS / `CLK_PERIOD_NS + 1)
`define EOI_WAIT_NS        1500
`define EOI_WAIT_CLKS      ((`EOI_WAIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define EOI_WAIT3_NS       600
`define EOI_WAIT3_CLKS     ((`EOI_WAIT3_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// ----------------------------------------
// command codes, status and mask bits
// ----------------------------------------
`define CMD_IACK       8'hF0
`define CMD_TAKE_CTL   8'hF1
`define CMD_PPOLL      8'hF2
`define CMD_IFC        8'hF3
`define CMD_REN_ON     8'hF4
`define CMD_REN_OFF    8'hF5
`define CMD_STANDBY    8'hF6
`define CMD_EVC_ON     8'hF7
`define CMD_TASK_DONE  8'hF8
`define CMD_EVC_LOAD   8'hF9
`define ST_OBF   0
`define ST_IBF   1
`define ST_IFC_RECEIVED_FLAG  2
`define ST_EV    4
`define ST_SRQ   5
`define ST_SYC   7
`define MSK_SRQ  0
`define MSK_INPUT_BUFFER_EMPTY_IRQ 2
`define MSK_OUTPUT_BUFFER_FULL_IRQ 3
`define MSK_SYC  4
`define MSK_TCI  5
`define MSK_SPI  6
`endif

// file: src/gpib_ctl.v
`timescale 1ns/1ps
`default_nettype none
`include "gpib_ctl_defs.vh"
module gpib_ctl #(
  parameter IFC_CLKS = `IFC_CLKS
) (
  input  wire       CLK,
  input  wire       ARST_N,
  input  wire       CS_N,
  input  wire       RD_N,
  input  wire       WR_N,
  input  wire       REGISTER_SELECT_LINE,
  input  wire [7:0] D_IN,
  output reg  [7:0] D_OUT,
  output reg        D_OE_N,
  output reg        SYNC,
  input  wire       COUNT,
  input  wire       LATCHED_IFC_INPUT,
  input  wire       SRQ_IN,
  input  wire       ATTENTION_MONITOR_INPUT,
  input  wire       SYSTEM_CONTROLLER_SWITCH,
  input  wire       EOI_IN,
  input  wire       THREE_STATE_DRIVERS,
  output reg        LATCH_CLEAR_OUTPUT,
  output reg        ATTENTION_DRIVE_OUTPUT,
  output reg        CONTROLLER_IN_CHARGE_OUTPUT,
  output reg        IFC_OUT,
  output reg        IFC_OE_N,
  output reg        REN_OUT,
  output reg        DAV_OUT,
  output reg        DAV_OE_N,
  output reg        EOI_OUT,
  output reg        EOI_OE_N,
  output reg        EOI_SAMPLED,
  output reg        TASK_COMPLETE_IRQ,
  output reg        SPI_IRQ,
  output reg        INPUT_BUFFER_EMPTY_IRQ,
  output reg        OUTPUT_BUFFER_FULL_IRQ
);
  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam [5:0] S_IDLE  = 6'h01;
  localparam [5:0] S_IFC   = 6'h02;
  localparam [5:0] S_ATN   = 6'h04;
  localparam [5:0] S_PPOLL = 6'h08;
  localparam [5:0] S_EOIW  = 6'h10;
  localparam [5:0] S_RENF  = 6'h20;
  // timing counts held at the width of the counters that load them
  localparam [5:0]  EVT_LAST = `EVT_SAMPLE_CLKS - 1;
  localparam [22:0] ATN_T    = `ATN_WAIT_CLKS;
  localparam [22:0] PPOLL_T  = `PPOLL_CLKS;
  localparam [22:0] EOIW_T   = `EOI_WAIT_CLKS;
  localparam [22:0] EOIW3_T  = `EOI_WAIT3_CLKS;

  reg  [1:0]  cs_s, rd_s, wr_s, a0_s, cnt_s, latched_ifc_input_s, srq_s, atn_s, syc_s, eoi_s, tsd_s;
  reg  [7:0]  din_s1, din_s2;
  reg         rd_d, wr_d, cnt_d, syc_d;
  reg  [3:0]  div;
  reg  [5:0]  pre;
  reg  [5:0]  state;
  reg  [22:0] tmr;
  reg  [7:0]  ibuf, obuf, mask, evc_init;
  reg         ibf, obf, evc_en, ack_pending;
  reg  [8:0]  evc;
  reg  [7:0]  status;
  reg         ren, controller_in_charge_output, task_complete_irq;
  wire        rd_fall  = rd_d & ~rd_s[1] & ~cs_s[1];
  wire        wr_rise  = ~wr_d & wr_s[1] & ~cs_s[1];
  wire        cnt_tick = (pre == 6'd0);
  wire        is_cmd   = a0_s[1];
  wire [7:0]  spi_src  = status & {1'b1, 1'b1, 1'b1, 1'b1, 4'h0};

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      {cs_s, rd_s, wr_s, a0_s, cnt_s, latched_ifc_input_s} <= 12'hFFF;
      {srq_s, atn_s, syc_s, eoi_s, tsd_s} <= 10'h000;
      din_s1 <= 8'h00;
      din_s2 <= 8'h00;
    end else begin
      cs_s   <= {cs_s[0], CS_N};
      rd_s   <= {rd_s[0], RD_N};
      wr_s   <= {wr_s[0], WR_N};
      a0_s   <= {a0_s[0], REGISTER_SELECT_LINE};
      cnt_s  <= {cnt_s[0], COUNT};
      latched_ifc_input_s <= {latched_ifc_input_s[0], LATCHED_IFC_INPUT};
      srq_s  <= {srq_s[0], SRQ_IN};
      atn_s  <= {atn_s[0], ATTENTION_MONITOR_INPUT};
      syc_s  <= {syc_s[0], SYSTEM_CONTROLLER_SWITCH};
      eoi_s  <= {eoi_s[0], EOI_IN};
      tsd_s  <= {tsd_s[0], THREE_STATE_DRIVERS};
      din_s1 <= D_IN;
      din_s2 <= din_s1;
    end
  end

  // ----------------------------------------
  // main control
  // ----------------------------------------
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rd_d <= 1'b1; wr_d <= 1'b1; cnt_d <= 1'b1; syc_d <= 1'b0;
      div <= 4'h0; pre <= 6'd0; SYNC <= 1'b0;
      state <= S_IDLE; tmr <= 23'd0;
      ibuf <= 8'h00; obuf <= 8'h00; mask <= 8'h00; evc_init <= 8'h00;
      ibf <= 1'b0; obf <= 1'b0; evc_en <= 1'b0; ack_pending <= 1'b0;
      evc <= 9'd255; status <= 8'h00;
      ren <= 1'b0; controller_in_charge_output <= 1'b0; task_complete_irq <= 1'b0;
      D_OUT <= 8'h00; D_OE_N <= 1'b1;
      LATCH_CLEAR_OUTPUT <= 1'b0; ATTENTION_DRIVE_OUTPUT <= 1'b0;
      CONTROLLER_IN_CHARGE_OUTPUT <= 1'b0;
      IFC_OUT <= 1'b0; IFC_OE_N <= 1'b1; REN_OUT <= 1'b0;
      DAV_OUT <= 1'b0; DAV_OE_N <= 1'b1; EOI_OUT <= 1'b0; EOI_OE_N <= 1'b1;
      EOI_SAMPLED <= 1'b0;
      TASK_COMPLETE_IRQ <= 1'b0; SPI_IRQ <= 1'b0;
      INPUT_BUFFER_EMPTY_IRQ <= 1'b0; OUTPUT_BUFFER_FULL_IRQ <= 1'b0;
    end else begin
      rd_d  <= rd_s[1];
      wr_d  <= wr_s[1];
      syc_d <= syc_s[1];
      // sync clock divider
      div  <= (div == 4'd`SYNC_DIV - 4'd1) ? 4'd0 : div + 4'd1;
      SYNC <= (div < 4'd7);
      // count input sampling
      pre <= (pre == EVT_LAST) ? 6'd0 : pre + 6'd1;
      if (cnt_tick) begin
        cnt_d <= cnt_s[1];
        if (evc_en && cnt_d && !cnt_s[1] && evc != 9'd0)
          evc <= evc - 9'd1;
      end
      if (evc_en && evc == 9'd0) begin
        status[`ST_EV] <= 1'b1;
        evc_en <= 1'b0;
      end
      // host bus read
      D_OE_N <= ~(~rd_s[1] & ~cs_s[1]);
      if (rd_fall) begin
        if (a0_s[1]) begin
          D_OUT <= {status[7:2], ibf, obf};
        end else begin
          D_OUT <= obuf;
          obf   <= 1'b0;
        end
      end
      // host bus write
      if (wr_rise) begin
        if (!is_cmd) begin
          mask <= din_s2;
        end else begin
          ibuf <= din_s2;
          ibf  <= 1'b1;
          task_complete_irq  <= 1'b0;
        end
      end
      // received ifc, monitored only when not system controller
      if (!syc_s[1] && latched_ifc_input_s[1] && !LATCH_CLEAR_OUTPUT) begin
        status[`ST_IFC_RECEIVED_FLAG] <= 1'b1;
        controller_in_charge_output <= 1'b0;
        LATCH_CLEAR_OUTPUT <= 1'b1;
      end else begin
        LATCH_CLEAR_OUTPUT <= 1'b0;
      end
      if (controller_in_charge_output && srq_s[1])
        status[`ST_SRQ] <= 1'b1;
      if (syc_s[1] != syc_d)
        status[`ST_SYC] <= 1'b1;
      // command execution and timed states
      case (state)
        S_IDLE: begin
          if (ibf && !(wr_rise && is_cmd)) begin
            ibf <= 1'b0;
            task_complete_irq <= 1'b1;
            case (ibuf)
              `CMD_IACK: status <= status & ~obuf;
              `CMD_TAKE_CTL: begin
                controller_in_charge_output <= 1'b1;
                ATTENTION_DRIVE_OUTPUT <= 1'b1;
                DAV_OUT <= 1'b1; DAV_OE_N <= 1'b0;
                tmr <= ATN_T; task_complete_irq <= 1'b0;
                state <= S_ATN;
              end
              `CMD_PPOLL: if (controller_in_charge_output) begin
                ATTENTION_DRIVE_OUTPUT <= 1'b1;
                EOI_OUT <= 1'b1; EOI_OE_N <= 1'b0;
                DAV_OUT <= 1'b1; DAV_OE_N <= 1'b0;
                tmr <= PPOLL_T; task_complete_irq <= 1'b0;
                state <= S_PPOLL;
              end
              `CMD_IFC: if (syc_s[1]) begin
                IFC_OUT <= 1'b1; IFC_OE_N <= 1'b0;
                controller_in_charge_output <= 1'b1;
                tmr <= IFC_CLKS[22:0]; task_complete_irq <= 1'b0;
                state <= S_IFC;
              end
              `CMD_REN_ON: if (syc_s[1]) ren <= 1'b1;
              `CMD_REN_OFF: if (syc_s[1]) begin
                ren <= 1'b0;
                tmr <= IFC_CLKS[22:0]; task_complete_irq <= 1'b0;
                state <= S_RENF;
              end
              `CMD_STANDBY: begin
                ATTENTION_DRIVE_OUTPUT <= 1'b0;
                tmr <= tsd_s[1] ? EOIW3_T : EOIW_T;
                task_complete_irq <= 1'b0;
                state <= S_EOIW;
              end
              `CMD_EVC_ON: begin
                evc    <= (evc_init == 8'h00) ? 9'd256 : {1'b0, evc_init};
                evc_en <= 1'b1;
              end
              `CMD_EVC_LOAD: evc_init <= obuf;
              default: begin
                obuf <= ibuf;
                obf  <= 1'b1;
              end
            endcase
          end
        end
        S_ATN, S_PPOLL, S_IFC, S_RENF, S_EOIW: begin
          if (tmr > 23'd1) begin
            tmr <= tmr - 23'd1;
          end else begin
            if (state == S_PPOLL) begin
              ATTENTION_DRIVE_OUTPUT <= 1'b0;
              EOI_OE_N <= 1'b1; EOI_OUT <= 1'b0;
            end
            if (state == S_EOIW)
              EOI_SAMPLED <= eoi_s[1];
            IFC_OUT <= 1'b0; IFC_OE_N <= 1'b1;
            DAV_OUT <= 1'b0; DAV_OE_N <= 1'b1;
            task_complete_irq   <= 1'b1;
            state <= S_IDLE;
          end
        end
        default: state <= S_IDLE;
      endcase
      REN_OUT                     <= ren;
      CONTROLLER_IN_CHARGE_OUTPUT <= controller_in_charge_output;
      TASK_COMPLETE_IRQ           <= task_complete_irq & mask[`MSK_TCI];
      SPI_IRQ                     <= status[`ST_IFC_RECEIVED_FLAG] | (mask[`MSK_SPI] & |spi_src);
      INPUT_BUFFER_EMPTY_IRQ      <= ~ibf & mask[`MSK_INPUT_BUFFER_EMPTY_IRQ];
      OUTPUT_BUFFER_FULL_IRQ      <= obf & mask[`MSK_OUTPUT_BUFFER_FULL_IRQ];
    end
  end
endmodule // gpib_ctl
`default_nettype wire

// file: sim/gpib_ctl_props.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// controller port checks
// ----------------------------------------
module gpib_ctl_props #(
  parameter IFC_CLKS = 20
) (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic REGISTER_SELECT_LINE,
  input wire logic D_OE_N,
  input wire logic SYNC,
  input wire logic LATCH_CLEAR_OUTPUT,
  input wire logic ATTENTION_DRIVE_OUTPUT,
  input wire logic IFC_OUT,
  input wire logic DAV_OE_N,
  input wire logic EOI_OE_N,
  input wire logic OUTPUT_BUFFER_FULL_IRQ
);
  logic [15:0] ifc_run;
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) ifc_run <= 16'h0000;
    else ifc_run <= IFC_OUT ? ifc_run + 16'h0001 : 16'h0000;
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  chk_sync_shape: assert property ($rose(SYNC) |-> SYNC[*7] ##1 !SYNC[*8] ##1 SYNC)
    else $error("sync period wrong");
  chk_clear_pulse: assert property (LATCH_CLEAR_OUTPUT |=> !LATCH_CLEAR_OUTPUT)
    else $error("latch clear not one cycle");
  chk_ifc_length: assert property ($fell(IFC_OUT) |-> ifc_run >= IFC_CLKS)
    else $error("ifc pulse short");
  chk_poll_length: assert property ($fell(EOI_OE_N) |-> ##79 !EOI_OE_N)
    else $error("poll too short");
  chk_identify_atn: assert property (!EOI_OE_N |-> ATTENTION_DRIVE_OUTPUT)
    else $error("eoi driven without atn");
  chk_dav_poll: assert property (!EOI_OE_N |-> !DAV_OE_N)
    else $error("dav not driven in poll");
  chk_atn_settle: assert property ($rose(ATTENTION_DRIVE_OUTPUT) |-> ##19 ATTENTION_DRIVE_OUTPUT)
    else $error("atn dropped early");
  chk_obf_read: assert property ($fell(D_OE_N) && !REGISTER_SELECT_LINE |-> ##[0:8] !OUTPUT_BUFFER_FULL_IRQ)
    else $error("obf not cleared by read");
endmodule // gpib_ctl_props
bind gpib_ctl gpib_ctl_props #(.IFC_CLKS(IFC_CLKS)) props (.CLK(CLK), .ARST_N(ARST_N),
  .REGISTER_SELECT_LINE(REGISTER_SELECT_LINE), .D_OE_N(D_OE_N), .SYNC(SYNC),
  .LATCH_CLEAR_OUTPUT(LATCH_CLEAR_OUTPUT), .ATTENTION_DRIVE_OUTPUT(ATTENTION_DRIVE_OUTPUT),
  .IFC_OUT(IFC_OUT), .DAV_OE_N(DAV_OE_N), .EOI_OE_N(EOI_OE_N), .OUTPUT_BUFFER_FULL_IRQ(OUTPUT_BUFFER_FULL_IRQ));
`default_nettype wire

// file: sim/gpib_far_side.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// bus lines as seen from the far side
// ----------------------------------------
module gpib_far_side (
  input  wire logic clk,
  input  wire logic atn_drive,
  input  wire logic eoi_oe_n,
  input  wire logic eoi_drive,
  input  wire logic srq_req,
  output logic      atn_mon,
  output logic      eoi_line,
  output logic      srq_line
);
  always_ff @(posedge clk) atn_mon <= atn_drive;
  assign eoi_line = !eoi_oe_n ? eoi_drive : 1'b0; // released line pulled false
  assign srq_line = srq_req;
endmodule // gpib_far_side
`default_nettype wire

// file: sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// controller testbench
// ----------------------------------------
module tb;
  localparam int IFC_N = 20;
  logic       clk, arst_n, cs_n, rd_n, wr_n, a0, count, lifc, srq, system_controller_switch;
  logic [7:0] d_in, q;
  logic       atn_mon, eoi_in, srq_in;
  wire  [7:0] d_out;
  wire        d_oe_n, sync, lclr, atn, controller_in_charge_output, ifc, ifc_oe_n, dav_oe_n, eoi_out, eoi_oe_n, task_complete_irq, spi, ibe, obf;
  int         bad_count, samples_checked, n, cyc;
  time        t0;
  gpib_ctl #(.IFC_CLKS(IFC_N)) dut (.CLK(clk), .ARST_N(arst_n), .CS_N(cs_n), .RD_N(rd_n), .WR_N(wr_n),
    .REGISTER_SELECT_LINE(a0), .D_IN(d_in), .D_OUT(d_out), .D_OE_N(d_oe_n), .SYNC(sync), .COUNT(count),
    .LATCHED_IFC_INPUT(lifc), .SRQ_IN(srq_in), .ATTENTION_MONITOR_INPUT(atn_mon),
    .SYSTEM_CONTROLLER_SWITCH(system_controller_switch), .EOI_IN(eoi_in), .THREE_STATE_DRIVERS(1'b0), .LATCH_CLEAR_OUTPUT(lclr),
    .ATTENTION_DRIVE_OUTPUT(atn), .CONTROLLER_IN_CHARGE_OUTPUT(controller_in_charge_output), .IFC_OUT(ifc), .IFC_OE_N(ifc_oe_n),
    .REN_OUT(), .DAV_OUT(), .DAV_OE_N(dav_oe_n), .EOI_OUT(eoi_out), .EOI_OE_N(eoi_oe_n), .EOI_SAMPLED(),
    .TASK_COMPLETE_IRQ(task_complete_irq), .SPI_IRQ(spi), .INPUT_BUFFER_EMPTY_IRQ(ibe), .OUTPUT_BUFFER_FULL_IRQ(obf));
  gpib_far_side far (.clk(clk), .atn_drive(atn), .eoi_oe_n(eoi_oe_n), .eoi_drive(eoi_out), .srq_req(srq),
    .atn_mon(atn_mon), .eoi_line(eoi_in), .srq_line(srq_in));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic sel, input logic [7:0] v);
    @(posedge clk);
    a0 <= sel;
    d_in <= v;
    cs_n <= 1'b0;
    wr_n <= 1'b0;
    repeat (4) @(posedge clk);
    wr_n <= 1'b1;
    repeat (3) @(posedge clk);
    cs_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
  task automatic rd(input logic sel);
    @(posedge clk);
    a0 <= sel;
    cs_n <= 1'b0;
    rd_n <= 1'b0;
    repeat (6) @(posedge clk);
    q = d_out;
    rd_n <= 1'b1;
    cs_n <= 1'b1;
    repeat (8) @(posedge clk);
  endtask
  task automatic close_out;
    $display("compared %0d mismatched %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      close_out();
    end
  end
  initial begin
    {arst_n, a0, d_in, lifc, srq} = '0;
    {cs_n, rd_n, wr_n, count, system_controller_switch} = 5'h1F;
    repeat (7) @(posedge clk);
    check({task_complete_irq, spi, ibe, obf, lclr, atn, controller_in_charge_output, ifc}, 8'h00);
    check({4'h0, d_oe_n, ifc_oe_n, dav_oe_n, eoi_oe_n}, 8'h0F);
    @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    @(posedge sync);
    t0 = $time;
    @(posedge sync);
    check(8'(($time - t0) / 25), 8'h0F);
    $display("test reset and sync done");
    wr(1'b0, 8'h6C);
    repeat (8) @(posedge clk);
    check(ibe, 1'b1);
    wr(1'b1, 8'h55);
    repeat (8) @(posedge clk);
    check(obf, 1'b1);
    rd(1'b1);
    check(q[0], 1'b1);
    rd(1'b0);
    check(q, 8'h55);
    check(obf, 1'b0);
    $display("test host port done");
    wr(1'b1, 8'hF3);
    for (n = 0; n < 50 && !ifc; n++) @(posedge clk);
    check(ifc_oe_n, 1'b0);
    for (n = 0; n < 500 && ifc; n++) @(posedge clk);
    repeat (10) @(posedge clk);
    check(task_complete_irq, 1'b1);
    $display("test interface clear done");
    wr(1'b1, 8'hF1);
    repeat (40) @(posedge clk);
    check(controller_in_charge_output, 1'b1);
    wr(1'b1, 8'hF2);
    repeat (120) @(posedge clk);
    $display("test take control and poll done");
    wr(1'b1, 8'h02);
    wr(1'b1, 8'hF9);
    wr(1'b1, 8'hF7);
    repeat (2) begin
      count <= 1'b0;
      repeat (100) @(posedge clk);
      count <= 1'b1;
      repeat (100) @(posedge clk);
    end
    rd(1'b1);
    check(q[4], 1'b1);
    $display("test event counter done");
    wr(1'b0, 8'h6D);
    wr(1'b1, 8'hFF);
    wr(1'b1, 8'hF0);
    repeat (4) @(posedge clk);
    check(spi, 1'b0);
    srq <= 1'b1;
    for (n = 0; n < 100 && !spi; n++) @(posedge clk);
    check(spi, 1'b1);
    srq <= 1'b0;
    repeat (4) @(posedge clk);
    wr(1'b1, 8'hF0);
    repeat (4) @(posedge clk);
    check(spi, 1'b0);
    wr(1'b0, 8'h2C);
    system_controller_switch <= 1'b0;
    lifc <= 1'b1;
    for (n = 0; n < 200 && !lclr; n++) @(posedge clk);
    check(lclr, 1'b1);
    lifc <= 1'b0;
    repeat (10) @(posedge clk);
    check(spi, 1'b1);
    $display("test service request and latched clear done");
    close_out();
  end
endmodule // tb
`default_nettype wire
